// >>> iafe_filter.sv
// Ingress access-control filter engine with Avalon-MM register slave
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
module iafe_filter #(
    parameter int ENTRIES = 16
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [9:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic pkt_valid_i,
    input wire logic [47:0] pkt_dst_mac_i,
    input wire logic [47:0] pkt_src_mac_i,
    input wire logic [15:0] pkt_ethertype_i,
    input wire logic pkt_is_ipv4_i,
    input wire logic [31:0] pkt_ip_src_i,
    input wire logic [31:0] pkt_ip_dst_i,
    input wire logic [7:0] pkt_ip_proto_i,
    input wire logic pkt_is_tcp_i,
    input wire logic pkt_is_udp_i,
    input wire logic [15:0] pkt_l4_src_i,
    input wire logic [15:0] pkt_l4_dst_i,
    input wire logic [7:0] pkt_tcp_flags_i,
    input wire logic [31:0] pkt_tcp_seq_i,
    output logic dec_valid_o,
    output logic dec_host_o,
    output logic dec_drop_o,
    output logic dec_remap_o,
    output logic [7:0] dec_port_map_o,
    output logic dec_hit_o,
    output logic [3:0] dec_action_o,
    output logic [15:0] count_event_o
);
    localparam int WORDS = iafe_pkg::TBL_WORDS;

    if (ENTRIES != 16) begin : g_chk
        $error("iafe_filter needs 16 entries");
    end

    logic auth_reg;
    logic [31:0] base_reg;
    logic wait_reg;
    logic busy_reg;
    logic [31:0] rdata_reg;
    logic last_hit_reg;
    logic [3:0] last_ptr_reg;
    logic [31:0] tbl_rd;
    logic [ENTRIES*WORDS*32-1:0] tbl_flat;
    logic tbl_sel;
    logic tbl_wr;
    logic [15:0] m_true;
    logic [15:0] p_true;
    logic [15:0] cnt_mode;
    logic [15:0] empty_mask;
    logic sel_hit;
    logic [3:0] sel_ptr;
    logic [31:0] sel_act;
    logic [31:0] mctl_w [16];
    logic [31:0] act_w [16];
    logic [31:0] proc_w [16];
    logic is_auth_frame;
    logic [5:0] us_div_reg;
    logic us_tick_reg;
    logic [9:0] ms_div_reg;
    logic ms_tick_reg;
    logic [10:0] cnt_reg [16];
    logic [15:0] armed_reg;
    logic [15:0] event_next;

    // ****************************************
    // Table access helpers
    // ****************************************
    function automatic logic [31:0] tw(input int i, input logic [2:0] w);
        tw = tbl_flat[(i * WORDS + int'(w)) * 32 +: 32];
    endfunction

    function automatic logic match_eval(input logic [31:0] lo, input logic [31:0] ctl, input logic [31:0] msk);
        logic [1:0] fs;
        logic r;
        logic valid;
        logic macok;
        logic typok;
        logic [47:0] mac;
        logic [31:0] ip;
        logic [15:0] prt;
        fs = ctl[iafe_pkg::MCTL_FSEL +: 2];
        mac = ctl[iafe_pkg::MCTL_SD] ? pkt_src_mac_i : pkt_dst_mac_i;
        ip = ctl[iafe_pkg::MCTL_SD] ? pkt_ip_src_i : pkt_ip_dst_i;
        prt = ctl[iafe_pkg::MCTL_SD] ? pkt_l4_src_i : pkt_l4_dst_i;
        macok = (mac == {ctl[15:0], lo});
        typok = (pkt_ethertype_i == msk[15:0]);
        r = 1'b0;
        valid = 1'b0;
        case (iafe_pkg::iafe_layer_t'(ctl[iafe_pkg::MCTL_LSEL +: 2]))
            iafe_pkg::LAY_L2: begin
                valid = 1'b1;
                case (fs)
                    2'h1: r = typok;
                    2'h2: r = macok;
                    default: r = macok && typok;
                endcase
            end
            iafe_pkg::LAY_L3: begin
                valid = pkt_is_ipv4_i && (fs == 2'h1 || fs == 2'h2);
                r = (fs == 2'h1) ? ((ip & msk) == (lo & msk)) : (pkt_ip_src_i == lo && pkt_ip_dst_i == msk);
            end
            iafe_pkg::LAY_L4: begin
                valid = pkt_is_ipv4_i;
                case (fs)
                    2'h0: r = (pkt_ip_proto_i == lo[7:0]);
                    2'h1: r = pkt_is_tcp_i && prt == lo[15:0] && (pkt_tcp_flags_i & msk[7:0]) == (ctl[7:0] & msk[7:0]);
                    2'h2: r = pkt_is_udp_i && prt == lo[15:0];
                    default: r = pkt_is_tcp_i && pkt_tcp_seq_i == lo;
                endcase
            end
            default: valid = 1'b0;
        endcase
        match_eval = valid && (ctl[iafe_pkg::MCTL_EQ] ? r : !r);
    endfunction

    // ****************************************
    // Register table
    // ****************************************
    assign tbl_sel = avs_address_i[9] && int'(avs_address_i[4:2]) < WORDS;
    assign tbl_wr = !wait_reg && avs_write_i && tbl_sel;

    iafe_table #(
        .ENTRIES(ENTRIES),
        .WORDS(WORDS)
    ) u_table (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .wr_en_i(tbl_wr),
        .wr_idx_i(avs_address_i[8:5]),
        .wr_word_i(avs_address_i[4:2]),
        .wr_data_i(avs_writedata_i),
        .rd_idx_i(avs_address_i[8:5]),
        .rd_word_i(avs_address_i[4:2]),
        .rd_data_o(tbl_rd),
        .flat_o(tbl_flat)
    );

    // ****************************************
    // Avalon slave handshake
    // ****************************************
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wait_reg <= 1'b1;
            busy_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else if (!wait_reg) begin
            wait_reg <= 1'b1;
            busy_reg <= 1'b0;
        end else if (busy_reg) begin
            wait_reg <= 1'b0;
            busy_reg <= 1'b0;
            if (tbl_sel) begin
                rdata_reg <= tbl_rd;
            end else begin
                case (avs_address_i)
                    iafe_pkg::CTRL_OFS: rdata_reg <= {31'h00000000, auth_reg};
                    iafe_pkg::BASE_OFS: rdata_reg <= base_reg;
                    iafe_pkg::STAT_OFS: rdata_reg <= {26'h0000000, last_ptr_reg, last_hit_reg, auth_reg};
                    default: rdata_reg <= 32'h00000000;
                endcase
            end
        end else if (avs_read_i || avs_write_i) begin
            busy_reg <= 1'b1;
        end
    end

    assign avs_waitrequest_o = wait_reg;
    assign avs_readdata_o = rdata_reg;

    // Host sets authorization only after a success verdict
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            auth_reg <= iafe_pkg::CTRL_AUTH_RST;
            base_reg <= iafe_pkg::BASE_RST;
        end else if (!wait_reg && avs_write_i) begin
            if (avs_address_i == iafe_pkg::CTRL_OFS) begin
                auth_reg <= avs_writedata_i[0];
            end
            if (avs_address_i == iafe_pkg::BASE_OFS) begin
                base_reg <= avs_writedata_i;
            end
        end
    end

    // ****************************************
    // Rule evaluation
    // ****************************************
    assign is_auth_frame = pkt_dst_mac_i == iafe_pkg::AUTH_DA
        || pkt_dst_mac_i == {base_reg, iafe_pkg::AUTH_LOW};

    always_comb begin
        sel_hit = 1'b0;
        sel_ptr = 4'h0;
        for (int i = 0; i < 16; i++) begin
            mctl_w[i] = tw(i, iafe_pkg::W_MCTL);
            act_w[i] = tw(i, iafe_pkg::W_ACT);
            proc_w[i] = tw(i, iafe_pkg::W_PROC);
            m_true[i] = match_eval(tw(i, iafe_pkg::W_MLO), mctl_w[i], tw(i, iafe_pkg::W_MASK));
            cnt_mode[i] = mctl_w[i][iafe_pkg::MCTL_FSEL +: 4] == 4'h4;
        end
        for (int i = 15; i >= 0; i--) begin
            empty_mask[i] = proc_w[i][15:0] == 16'h0000;
            p_true[i] = !empty_mask[i]
                && (m_true & proc_w[i][15:0]) == proc_w[i][15:0];
            if (p_true[i]) begin
                sel_hit = 1'b1;
                sel_ptr = proc_w[i][iafe_pkg::PROC_PTR +: 4];
            end
        end
        sel_act = act_w[sel_ptr];
    end

    // ****************************************
    // Per-packet decision
    // ****************************************
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dec_valid_o <= 1'b0;
            dec_host_o <= 1'b0;
            dec_drop_o <= 1'b0;
            dec_remap_o <= 1'b0;
            dec_port_map_o <= 8'h00;
            dec_hit_o <= 1'b0;
            dec_action_o <= 4'h0;
        end else begin
            dec_valid_o <= pkt_valid_i;
            dec_host_o <= 1'b0;
            dec_drop_o <= 1'b0;
            dec_remap_o <= 1'b0;
            dec_port_map_o <= 8'h00;
            dec_hit_o <= pkt_valid_i && sel_hit;
            dec_action_o <= sel_ptr;
            if (pkt_valid_i) begin
                if (is_auth_frame) begin
                    dec_host_o <= 1'b1;
                end else if (!auth_reg) begin
                    dec_drop_o <= 1'b1;
                end else if (sel_hit && !cnt_mode[sel_ptr]) begin
                    case (iafe_pkg::iafe_act_t'(sel_act[iafe_pkg::ACT_KIND +: 2]))
                        iafe_pkg::ACT_DROP: dec_drop_o <= 1'b1;
                        iafe_pkg::ACT_HOST: dec_host_o <= 1'b1;
                        iafe_pkg::ACT_REMAP: begin
                            dec_remap_o <= 1'b1;
                            dec_port_map_o <= sel_act[iafe_pkg::ACT_PMAP +: iafe_pkg::PMAP_W];
                        end
                        default: dec_remap_o <= 1'b0;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            last_hit_reg <= 1'b0;
            last_ptr_reg <= 4'h0;
        end else if (pkt_valid_i) begin
            last_hit_reg <= sel_hit;
            last_ptr_reg <= sel_ptr;
        end
    end

    // ****************************************
    // Count timebase
    // ****************************************
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            us_div_reg <= 6'h00;
            us_tick_reg <= 1'b0;
            ms_div_reg <= 10'h000;
            ms_tick_reg <= 1'b0;
        end else begin
            us_tick_reg <= us_div_reg == 6'(iafe_pkg::CYC_PER_US - 1);
            us_div_reg <= (us_div_reg == 6'(iafe_pkg::CYC_PER_US - 1)) ? 6'h00 : us_div_reg + 6'h01;
            ms_tick_reg <= us_tick_reg && ms_div_reg == 10'(iafe_pkg::MS_US - 1);
            if (us_tick_reg) begin
                ms_div_reg <= (ms_div_reg == 10'(iafe_pkg::MS_US - 1)) ? 10'h000 : ms_div_reg + 10'h001;
            end
        end
    end

    // ****************************************
    // Watchdog and event counters
    // ****************************************
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            armed_reg <= 16'h0000;
            for (int i = 0; i < 16; i++) begin
                cnt_reg[i] <= 11'h000;
            end
        end else begin
            for (int i = 0; i < 16; i++) begin
                if (!cnt_mode[i]) begin
                    cnt_reg[i] <= 11'h000;
                    armed_reg[i] <= 1'b0;
                end else if (act_w[i][iafe_pkg::ACT_ALGO]) begin
                    armed_reg[i] <= 1'b0;
                    if (pkt_valid_i && m_true[i]) begin
                        cnt_reg[i] <= event_next[i] ? 11'h000 : cnt_reg[i] + 11'h001;
                    end
                end else if (pkt_valid_i && m_true[i]) begin
                    cnt_reg[i] <= act_w[i][iafe_pkg::ACT_CNT_W-1:0];
                    armed_reg[i] <= 1'b1;
                end else if (event_next[i]) begin
                    cnt_reg[i] <= 11'h000;
                    armed_reg[i] <= 1'b0;
                end else if (armed_reg[i] && (act_w[i][iafe_pkg::ACT_UNIT] ? ms_tick_reg : us_tick_reg)) begin
                    cnt_reg[i] <= cnt_reg[i] - 11'h001;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (act_w[i][iafe_pkg::ACT_ALGO]) begin
                event_next[i] = cnt_mode[i] && pkt_valid_i && m_true[i]
                    && cnt_reg[i] + 11'h001 >= act_w[i][iafe_pkg::ACT_CNT_W-1:0];
            end else begin
                event_next[i] = cnt_mode[i] && armed_reg[i] && !(pkt_valid_i && m_true[i])
                    && cnt_reg[i] == 11'h000;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_event_o <= 16'h0000;
        end else begin
            count_event_o <= event_next;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    AST_AUTH_HOST: assert property (pkt_valid_i && is_auth_frame |=> dec_valid_o && dec_host_o && !dec_drop_o)
        else $error("authentication frame not sent to host");
    AST_UNAUTH_DROP: assert property (pkt_valid_i && !is_auth_frame && !auth_reg |=> dec_drop_o && !dec_remap_o)
        else $error("user frame passed on unauthorized port");
    AST_PASS_NEEDS_AUTH: assert property (dec_valid_o && !dec_drop_o && !dec_host_o |-> $past(auth_reg))
        else $error("traffic passed without authorization");
    AST_EVERY_PACKET: assert property (pkt_valid_i |=> dec_valid_o ##1 (dec_valid_o == $past(pkt_valid_i)))
        else $error("packet without decision");
    AST_ONE_ACTION: assert property (dec_valid_o |-> $onehot0({dec_drop_o, dec_host_o, dec_remap_o}))
        else $error("more than one action on a packet");
    AST_PRIORITY: assert property (pkt_valid_i && p_true[0] |=> dec_hit_o
        && dec_action_o == $past(proc_w[0][iafe_pkg::PROC_PTR +: 4]))
        else $error("entry 0 did not take priority");
    AST_EMPTY_MASK: assert property (pkt_valid_i && (empty_mask == 16'hffff) |=> !dec_hit_o)
        else $error("empty select mask produced a hit");
    AST_US_TICK: assert property (us_tick_reg |=> !us_tick_reg [*8])
        else $error("microsecond tick too frequent");
    AST_CNT_NO_ACTION: assert property (pkt_valid_i && auth_reg && !is_auth_frame && sel_hit && cnt_mode[sel_ptr]
        |=> !dec_drop_o && !dec_host_o && !dec_remap_o)
        else $error("counting entry produced an action");
endmodule

// >>> iafe_pkg.sv
// Constants, field layouts and types for the ingress filter engine
// Operation
// - Detect authentication frames by destination address
// - Redirect authentication frames to host port
// - Unauthorized port blocks user frames
// - Only success verdict authorizes the port
// - Ordered filter list of 16 rules
// - Compare MAC, EtherType, IPv4, protocol, ports, flags
// - Filter verdict overrides other forwarding results
// - Watchdog interrupt when matching packet missing
// - Event interrupt after programmed packet count
// - Counting entry holds count, no action
// - Otherwise matching and action rules independent
// - Select mask ANDs selected matching rules
// - Four-bit pointer names the action rule
// - Entries sharing an action are ORed
// - Lowest true processing entry wins
// - Only one action per packet
// - Layer selector encodes off, L2, L3, L4
// - Unit bit selects microseconds or milliseconds
// - Algorithm bit selects countdown or packet count
package iafe_pkg;
    // ****************************************
    // Bus map
    // ****************************************
    localparam int ADDR_W = 10;
    localparam logic [9:0] CTRL_OFS = 10'h000;
    localparam logic [9:0] BASE_OFS = 10'h004;
    localparam logic [9:0] STAT_OFS = 10'h008;
    localparam logic [9:0] TBL_OFS = 10'h200;
    localparam int TBL_WORDS = 5;
    localparam logic [2:0] W_MLO = 3'h0;
    localparam logic [2:0] W_MCTL = 3'h1;
    localparam logic [2:0] W_MASK = 3'h2;
    localparam logic [2:0] W_ACT = 3'h3;
    localparam logic [2:0] W_PROC = 3'h4;
    localparam logic [31:0] BASE_RST = 32'h0180c200;
    localparam logic CTRL_AUTH_RST = 1'b0;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int MCTL_EQ = 16;
    localparam int MCTL_SD = 17;
    localparam int MCTL_FSEL = 18;
    localparam int MCTL_LSEL = 20;
    localparam int ACT_CNT_W = 11;
    localparam int ACT_PMAP = 16;
    localparam int ACT_UNIT = 27;
    localparam int ACT_ALGO = 28;
    localparam int ACT_KIND = 29;
    localparam int PROC_PTR = 16;
    localparam int PMAP_W = 8;
    // ****************************************
    // Frame addresses and timing
    // ****************************************
    localparam logic [47:0] AUTH_DA = 48'h0180c2000003;
    localparam logic [15:0] AUTH_LOW = 16'h0003;
    localparam int CLK_PERIOD_NS = 20;
    localparam int US_NS = 1000;
    localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_US = 1000;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {LAY_OFF, LAY_L2, LAY_L3, LAY_L4} iafe_layer_t;
    typedef enum logic [1:0] {ACT_NONE, ACT_DROP, ACT_HOST, ACT_REMAP} iafe_act_t;
endpackage

// >>> iafe_table.sv
// Rule table storage with registered read port and parallel view
`timescale 1ns/1ns
module iafe_table #(
    parameter int ENTRIES = 16,
    parameter int WORDS = 5
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic wr_en_i,
    input wire logic [3:0] wr_idx_i,
    input wire logic [2:0] wr_word_i,
    input wire logic [31:0] wr_data_i,
    input wire logic [3:0] rd_idx_i,
    input wire logic [2:0] rd_word_i,
    output logic [31:0] rd_data_o,
    output logic [ENTRIES*WORDS*32-1:0] flat_o
);
    logic [31:0] mem_reg [ENTRIES*WORDS];

    if (ENTRIES < 1 || ENTRIES > 16 || WORDS < 1 || WORDS > 8) begin : g_chk
        $error("iafe_table size not supported");
    end

    // Cleared table leaves every matching rule disabled
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int k = 0; k < ENTRIES * WORDS; k++) begin
                mem_reg[k] <= 32'h00000000;
            end
        end else if (wr_en_i && int'(wr_idx_i) < ENTRIES && int'(wr_word_i) < WORDS) begin
            mem_reg[int'(wr_idx_i) * WORDS + int'(wr_word_i)] <= wr_data_i;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_data_o <= 32'h00000000;
        end else if (int'(rd_idx_i) < ENTRIES && int'(rd_word_i) < WORDS) begin
            rd_data_o <= mem_reg[int'(rd_idx_i) * WORDS + int'(rd_word_i)];
        end else begin
            rd_data_o <= 32'h00000000;
        end
    end

    always_comb begin
        for (int k = 0; k < ENTRIES * WORDS; k++) begin
            flat_o[k*32 +: 32] = mem_reg[k];
        end
    end
endmodule

// >>> iafe_pkt_src.sv
// Ingress packet path model driving frame headers
`timescale 1ns/1ns
module iafe_pkt_src (
    input wire logic mclk_i,
    output logic pv_o,
    output logic [47:0] pd_o,
    output logic [47:0] ps_o,
    output logic [15:0] pt_o,
    output logic [31:0] pa_o
);
    initial begin
        pv_o = 1'b0;
        pd_o = 48'h0;
        ps_o = 48'h0;
        pt_o = 16'h0;
        pa_o = 32'h0;
    end
    // One header pulse, fields inverted once released
    task send(input logic [47:0] d, input logic [47:0] s, input logic [15:0] t, input logic [31:0] a);
        @(posedge mclk_i);
        pv_o <= 1'b1;
        pd_o <= d;
        ps_o <= s;
        pt_o <= t;
        pa_o <= a;
        @(posedge mclk_i);
        pv_o <= 1'b0;
        pd_o <= ~d;
        ps_o <= ~s;
        pt_o <= ~t;
        pa_o <= ~a;
    endtask
endmodule

// >>> iafe_filter_bench.sv
// Bench for the ingress filter engine
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module iafe_filter_bench;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [9:0] addr = 10'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat_o;
    logic wait_o;
    logic pv;
    logic [47:0] pd;
    logic [47:0] ps;
    logic [15:0] pt;
    logic [31:0] pa;
    logic dv, dh, dd, dr, dhit;
    logic [3:0] dact;
    logic [7:0] dmap;
    logic [15:0] cev;
    int err_count = 0;
    int total_checks = 0;
    always #10 mclk_i = ~mclk_i;
    iafe_pkt_src u_iafe_pkt_src (.mclk_i(mclk_i), .pv_o(pv), .pd_o(pd), .ps_o(ps), .pt_o(pt), .pa_o(pa));
    iafe_filter u_iafe_filter (.mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat_o),
        .avs_waitrequest_o(wait_o), .pkt_valid_i(pv), .pkt_dst_mac_i(pd), .pkt_src_mac_i(ps),
        .pkt_ethertype_i(pt), .pkt_is_ipv4_i(pt == 16'h0800), .pkt_ip_src_i(pa), .pkt_ip_dst_i(~pa),
        .pkt_ip_proto_i(pa[7:0]), .pkt_is_tcp_i(pa[8]), .pkt_is_udp_i(pa[9]), .pkt_l4_src_i(pa[15:0]),
        .pkt_l4_dst_i(pa[31:16]), .pkt_tcp_flags_i(pa[23:16]), .pkt_tcp_seq_i(pa), .dec_valid_o(dv),
        .dec_host_o(dh), .dec_drop_o(dd), .dec_remap_o(dr), .dec_port_map_o(dmap), .dec_hit_o(dhit),
        .dec_action_o(dact), .count_event_o(cev));
    // ****
    // Tasks
    // ****
    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task bus(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk_i);
        addr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        @(posedge mclk_i);
        while (wait_o !== 1'b0 && n < 20) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 20) begin
            err_count++;
            complete_run();
        end
        q = rdat_o;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task wr32(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task rchk(input logic [9:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK("readdata", e, q)
    endtask
    function automatic logic [9:0] ta(input int e, input int w);
        return iafe_pkg::TBL_OFS + 10'(e * 32 + w * 4);
    endfunction
    // Vector: valid host drop remap hit action map
    task pkt(input logic [47:0] d, input logic [15:0] t, input logic [16:0] e);
        u_iafe_pkt_src.send(d, 48'h020000000001, t, 32'h0a000001);
        @(negedge mclk_i);
        `CHK("decision", e, {dv, dh, dd, dr, dhit, dhit ? dact : 4'h0, dmap})
    endtask
    // ****
    // Sequence
    // ****
    initial begin
        int n;
        repeat (6) @(posedge mclk_i);
        resetn_i <= 1'b1;
        rchk(iafe_pkg::CTRL_OFS, 32'h0);
        rchk(iafe_pkg::BASE_OFS, iafe_pkg::BASE_RST);
        rchk(ta(15, 1), 32'h0);
        rchk(10'h3fc, 32'h0);
        pkt(48'h0a0000000001, 16'h0800, 17'h14000);
        $display("T1 reset done");
        pkt(48'h0180c2000003, 16'h888e, 17'h18000);
        wr32(iafe_pkg::BASE_OFS, 32'h12345678);
        pkt(48'h123456780003, 16'h888e, 17'h18000);
        pkt(48'h123456780004, 16'h888e, 17'h14000);
        wr32(iafe_pkg::CTRL_OFS, 32'h1);
        pkt(48'h0a0000000001, 16'h0800, 17'h10000);
        pkt(48'h0180c2000003, 16'h888e, 17'h18000);
        $display("T2 auth done");
        wr32(ta(0, 1), 32'h00150000);
        wr32(ta(0, 2), 32'h00000800);
        wr32(ta(1, 1), 32'h00150000);
        wr32(ta(1, 2), 32'h000086dd);
        wr32(ta(2, 3), 32'h20000000);
        wr32(ta(3, 3), 32'h605a0000);
        wr32(ta(0, 4), 32'h00030003);
        wr32(ta(1, 4), 32'h00020001);
        wr32(ta(2, 4), 32'h00030001);
        wr32(ta(3, 4), 32'h00020002);
        rchk(ta(0, 1), 32'h00150000);
        rchk(ta(0, 5), 32'h0);
        pkt(48'h0a0000000001, 16'h0800, 17'h15200);
        pkt(48'h0a0000000001, 16'h86dd, 17'h15200);
        pkt(48'h0a0000000001, 16'h1234, 17'h10000);
        wr32(ta(1, 4), 32'h00020000);
        pkt(48'h0a0000000001, 16'h0800, 17'h1335a);
        rchk(iafe_pkg::STAT_OFS, 32'h0000000f);
        wr32(ta(0, 4), 32'h00020001);
        pkt(48'h0a0000000001, 16'h0800, 17'h15200);
        $display("T3 acl done");
        wr32(ta(4, 0), 32'hbbccddee);
        wr32(ta(4, 1), 32'h001102aa);
        wr32(ta(4, 2), 32'h000088b5);
        wr32(ta(4, 3), 32'h10000003);
        wr32(ta(5, 4), 32'h00040010);
        for (int i = 1; i <= 3; i++) begin
            pkt(48'h02aabbccddee, 16'h88b5, 17'h11400);
            `CHK("event", (i == 3) ? 16'h0010 : 16'h0000, cev)
        end
        wr32(ta(5, 0), 32'hbbccdd01);
        wr32(ta(5, 1), 32'h001102aa);
        wr32(ta(5, 2), 32'h000088b6);
        wr32(ta(5, 3), 32'h00000002);
        pkt(48'h02aabbccdd01, 16'h88b6, 17'h10000);
        n = 0;
        while (cev[5] !== 1'b1 && n < 300) begin
            @(negedge mclk_i);
            n++;
        end
        `CHK("wd_event", 16'h0020, cev)
        `CHK("wd_delay", 1'b1, n >= 40 && n <= 110)
        $display("T4 count done");
        wr32(ta(6, 0), 32'h0a000000);
        wr32(ta(6, 1), 32'h00270000);
        wr32(ta(6, 2), 32'hffffff00);
        wr32(ta(0, 4), 32'h00020040);
        pkt(48'h0a0000000001, 16'h0800, 17'h15200);
        $display("T5 ip done");
        complete_run();
    end
endmodule
